/* File: hw/tpg_pkg.sv */
// Constants for the transmit power gear and pulse shaping controller.
// Assumes a single 40 MHz clock and a simple strobe register port.
package tpg_pkg;

   // -------------------------------------------------------------------------
   // Sizes
   // -------------------------------------------------------------------------
   localparam int GEAR_MAX = 8;
   localparam int GEAR_W   = 3;
   localparam int AGC_W    = 10;
   localparam int ADDR_W   = 8;

   // -------------------------------------------------------------------------
   // Register byte offsets
   // -------------------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL       = 8'h00;
   localparam logic [7:0] OFS_GEAR_COUNT = 8'h04;
   localparam logic [7:0] OFS_SHIFT      = 8'h08;
   localparam logic [7:0] OFS_STATUS     = 8'h0C;
   localparam logic [7:0] OFS_SET_BASE   = 8'h20;
   localparam logic [7:0] OFS_THR_BASE   = 8'h40;

   // -------------------------------------------------------------------------
   // Field positions
   // -------------------------------------------------------------------------
   localparam int CTRL_EN_BIT      = 0;
   localparam int CTRL_FULLAM_BIT  = 1;
   localparam int CTRL_BYPASS_BIT  = 2;
   localparam int CTRL_USLEN_LSB   = 4;
   localparam int CTRL_RISELEN_LSB = 8;
   localparam int SET_POWER_LSB    = 0;
   localparam int SET_FALL_LSB     = 8;
   localparam int SET_RISE_LSB     = 12;
   localparam int SET_RESID_LSB    = 16;
   localparam int STAT_GEAR_LSB    = 0;
   localparam int STAT_SHAPE_LSB   = 4;
   localparam int STAT_AGC_LSB     = 16;

   // -------------------------------------------------------------------------
   // Reset values and levels
   // -------------------------------------------------------------------------
   localparam logic [11:0] CTRL_RESET       = 12'h000;
   localparam logic [3:0]  GEAR_COUNT_RESET = 4'h1;
   localparam logic [3:0]  SHIFT_RESET      = 4'h0;
   localparam logic [6:0]  CARRIER_FULL     = 7'h7F;
   localparam logic [6:0]  CARRIER_OFF      = 7'h00;

   typedef enum logic [1:0] {
      TPG_SH_CW,
      TPG_SH_FALL,
      TPG_SH_MOD,
      TPG_SH_RISE
   } tpg_shape_t;

endpackage

/* File: hw/tpg_mem_if.sv */
// Carrier between the controller and its gear settings memory.
// Assumes both ends run on clk_sys.
`timescale 1ns/1ps
interface tpg_mem_if;
   logic [2:0]  a_addr;
   logic [31:0] a_data;
   logic [2:0]  b_addr;
   logic [31:0] b_data;
   logic        wr_en;
   logic [2:0]  wr_addr;
   logic [31:0] wr_data;

   modport mem  (input a_addr, input b_addr, input wr_en, input wr_addr, input wr_data,
                 output a_data, output b_data);
   modport user (output a_addr, output b_addr, output wr_en, output wr_addr, output wr_data,
                 input a_data, input b_data);
endinterface

/* File: hw/tpg_gear_mem.sv */
// Per-gear transmitter settings store with one write and two registered reads.
// Assumes the user keeps addresses in range; reads return the word of the previous cycle.
`timescale 1ns/1ps
module tpg_gear_mem (
   input  wire logic clk_sys,
   input  wire logic rst_b,
   input  wire logic ce,
   tpg_mem_if.mem    mp
);
   logic [31:0] ram [tpg_pkg::GEAR_MAX];
   logic [31:0] next_a_data;
   logic [31:0] next_b_data;

   always_comb begin
      next_a_data = ram[mp.a_addr];
      next_b_data = ram[mp.b_addr];
   end

   always_ff @(posedge clk_sys) begin
      if (ce && mp.wr_en) begin
         ram[mp.wr_addr] <= mp.wr_data;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         mp.a_data <= 32'h0000_0000;
         mp.b_data <= 32'h0000_0000;
      end else if (ce) begin
         mp.a_data <= next_a_data;
         mp.b_data <= next_b_data;
      end
   end
endmodule

/* File: hw/tpg_ctrl.sv */
// Transmit power gear controller with four-state pulse shaping sequencer.
// Assumes agc_value/agc_valid and mod_req come from logic on clk_sys.
//
// Operation
// - Hold an upper gain threshold per gear; exceeding the current one advances a gear.
// - Gear zero is maximum power and the starting gear.
// - Higher-numbered gears apply lower power, lowering supply current and gain.
// - Configuration: gear count, per-gear settings, low threshold shift, upper thresholds.
// - The gear table is indexed from gear zero upward.
// - Carrier changes between unmodulated and modulated in steps, not abruptly.
// - Each pulse runs carrier, undershoot pattern, modulated carrier, rising edge.
// - Modulated state switches the carrier off or drives a reduced residual level.
// - The fourth state applies switched-capacitor shaping to the rising edge.
// - Fall and rise time constants come from the current gear entry.
//
// The register offsets and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
module tpg_ctrl (
   input  wire logic        clk_sys,
   input  wire logic        rst_b,
   input  wire logic        ce,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [31:0] reg_rdata,
   input  wire logic [9:0]  agc_value,
   input  wire logic        agc_valid,
   input  wire logic        mod_req,
   output logic      [2:0]  gear,
   output logic      [7:0]  tx_power_level,
   output logic      [3:0]  tau_fall,
   output logic      [3:0]  tau_rise,
   output logic      [6:0]  carrier_level,
   output logic             undershoot_en,
   output logic             switched_cap_rise_shaping_en,
   output logic      [1:0]  shape_state
);
   tpg_mem_if mp ();

   tpg_gear_mem u_mem (
      .clk_sys (clk_sys),
      .rst_b   (rst_b),
      .ce      (ce),
      .mp      (mp.mem)
   );

   // ----------------------------------------------------------------------
   // Register port
   // ----------------------------------------------------------------------
   logic [11:0] ctrl, next_ctrl;
   logic [3:0]  gear_count, next_gear_count;
   logic [3:0]  shift, next_shift;
   logic [9:0]  agc_last, next_agc_last;
   logic [31:0] rd_word, next_rd_word;
   logic        rd_tab, next_rd_tab;
   logic [9:0]  thr [tpg_pkg::GEAR_MAX];
   logic        hit_set, hit_thr;
   tpg_pkg::tpg_shape_t state, next_state;

   always_comb begin
      hit_set = (reg_addr[7:5] == tpg_pkg::OFS_SET_BASE[7:5]) && (reg_addr[1:0] == 2'h0);
      hit_thr = (reg_addr[7:5] == tpg_pkg::OFS_THR_BASE[7:5]) && (reg_addr[1:0] == 2'h0);
      next_ctrl       = ctrl;
      next_gear_count = gear_count;
      next_shift      = shift;
      next_agc_last   = agc_valid ? agc_value : agc_last;
      next_rd_word    = 32'h0000_0000;
      next_rd_tab     = 1'b0;
      mp.wr_en   = reg_wr && hit_set;
      mp.wr_addr = reg_addr[4:2];
      mp.wr_data = reg_wdata;
      mp.b_addr  = reg_addr[4:2];
      if (reg_wr) begin
         unique case (reg_addr)
            tpg_pkg::OFS_CTRL:       next_ctrl = reg_wdata[11:0];
            tpg_pkg::OFS_GEAR_COUNT: next_gear_count = reg_wdata[3:0];
            tpg_pkg::OFS_SHIFT:      next_shift = reg_wdata[3:0];
            default:                 next_ctrl = ctrl;
         endcase
      end
      if (reg_rd) begin
         unique case (reg_addr)
            tpg_pkg::OFS_CTRL:       next_rd_word = {20'h0_0000, ctrl};
            tpg_pkg::OFS_GEAR_COUNT: next_rd_word = {28'h000_0000, gear_count};
            tpg_pkg::OFS_SHIFT:      next_rd_word = {28'h000_0000, shift};
            tpg_pkg::OFS_STATUS:     next_rd_word = {6'h00, agc_last, 10'h000, state, 1'b0, gear};
            default: begin
               if (hit_thr) begin
                  next_rd_word = {22'h00_0000, thr[reg_addr[4:2]]};
               end
               next_rd_tab = hit_set;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         ctrl       <= tpg_pkg::CTRL_RESET;
         gear_count <= tpg_pkg::GEAR_COUNT_RESET;
         shift      <= tpg_pkg::SHIFT_RESET;
         agc_last   <= 10'h000;
         rd_word    <= 32'h0000_0000;
         rd_tab     <= 1'b0;
      end else if (ce) begin
         ctrl       <= next_ctrl;
         gear_count <= next_gear_count;
         shift      <= next_shift;
         agc_last   <= next_agc_last;
         rd_word    <= next_rd_word;
         rd_tab     <= next_rd_tab;
      end
   end

   assign reg_rdata = rd_tab ? mp.b_data : rd_word;

   // Upper gain threshold per gear, one register each.
   genvar gi;
   generate
      for (gi = 0; gi < tpg_pkg::GEAR_MAX; gi++) begin : g_thr
         logic [9:0] next_thr;
         always_comb begin
            next_thr = thr[gi];
            if (reg_wr && hit_thr && (reg_addr[4:2] == 3'(gi))) begin
               next_thr = reg_wdata[9:0];
            end
         end
         always_ff @(posedge clk_sys or negedge rst_b) begin
            if (!rst_b) begin
               thr[gi] <= 10'h3FF;
            end else if (ce) begin
               thr[gi] <= next_thr;
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------------
   // Gear selection
   // ----------------------------------------------------------------------
   logic       en, full_am, sc_bypass;
   logic [3:0] us_len, rise_len;
   logic [2:0] gear_last, next_gear;
   logic [9:0] thr_cur, thr_prev, low_thr;
   logic       go_up, go_down;

   always_comb begin
      en        = ctrl[tpg_pkg::CTRL_EN_BIT];
      full_am   = ctrl[tpg_pkg::CTRL_FULLAM_BIT];
      sc_bypass = ctrl[tpg_pkg::CTRL_BYPASS_BIT];
      us_len    = ctrl[tpg_pkg::CTRL_USLEN_LSB +: 4];
      rise_len  = ctrl[tpg_pkg::CTRL_RISELEN_LSB +: 4];
      // A count of zero behaves as one gear; counts above the table size are clipped.
      if (gear_count == 4'h0) begin
         gear_last = 3'h0;
      end else if (gear_count > 4'h8) begin
         gear_last = 3'h7;
      end else begin
         gear_last = 3'(gear_count - 4'h1);
      end
      thr_cur  = thr[gear];
      thr_prev = thr[3'(gear - 3'h1)];
      // The low threshold sits below the previous gear's upper threshold by a shifted fraction.
      low_thr  = (shift == 4'h0) ? 10'h000 : 10'(thr_prev - (thr_prev >> shift));
      go_up    = agc_valid && (agc_value > thr_cur) && (gear < gear_last);
      go_down  = agc_valid && (gear != 3'h0) && (agc_value < low_thr);
      next_gear = gear;
      if (!en) begin
         next_gear = 3'h0;
      end else if (gear > gear_last) begin
         next_gear = gear_last;
      end else if (go_up) begin
         next_gear = 3'(gear + 3'h1);
      end else if (go_down) begin
         next_gear = 3'(gear - 3'h1);
      end
      mp.a_addr = gear;
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         gear <= 3'h0;
      end else if (ce) begin
         gear <= next_gear;
      end
   end

   // ----------------------------------------------------------------------
   // Pulse shaping sequencer
   // ----------------------------------------------------------------------
   logic [3:0] cnt, next_cnt;
   logic [6:0] resid, next_carrier;
   logic [7:0] next_power;
   logic [3:0] next_fall, next_rise;

   always_comb begin
      next_state = state;
      next_cnt   = 4'h0;
      unique case (state)
         tpg_pkg::TPG_SH_CW: begin
            if (mod_req) begin
               next_state = tpg_pkg::TPG_SH_FALL;
            end
         end
         tpg_pkg::TPG_SH_FALL: begin
            if (cnt == us_len) begin
               next_state = tpg_pkg::TPG_SH_MOD;
            end else begin
               next_cnt = 4'(cnt + 4'h1);
            end
         end
         tpg_pkg::TPG_SH_MOD: begin
            if (!mod_req) begin
               next_state = tpg_pkg::TPG_SH_RISE;
            end
         end
         tpg_pkg::TPG_SH_RISE: begin
            if (cnt == rise_len) begin
               next_state = tpg_pkg::TPG_SH_CW;
            end else begin
               next_cnt = 4'(cnt + 4'h1);
            end
         end
      endcase
      resid = mp.a_data[tpg_pkg::SET_RESID_LSB +: 7];
      // Transitions use the gear's residual carrier; the modulated state may cut it fully.
      unique case (next_state)
         tpg_pkg::TPG_SH_CW:  next_carrier = tpg_pkg::CARRIER_FULL;
         tpg_pkg::TPG_SH_MOD: next_carrier = full_am ? tpg_pkg::CARRIER_OFF : resid;
         default:             next_carrier = resid;
      endcase
      next_power = mp.a_data[tpg_pkg::SET_POWER_LSB +: 8];
      next_fall  = mp.a_data[tpg_pkg::SET_FALL_LSB +: 4];
      next_rise  = mp.a_data[tpg_pkg::SET_RISE_LSB +: 4];
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         state          <= tpg_pkg::TPG_SH_CW;
         cnt            <= 4'h0;
         carrier_level  <= tpg_pkg::CARRIER_FULL;
         undershoot_en  <= 1'b0;
         switched_cap_rise_shaping_en  <= 1'b0;
         tx_power_level <= 8'h00;
         tau_fall       <= 4'h0;
         tau_rise       <= 4'h0;
      end else if (ce) begin
         state          <= next_state;
         cnt            <= next_cnt;
         carrier_level  <= next_carrier;
         undershoot_en  <= (next_state == tpg_pkg::TPG_SH_FALL);
         switched_cap_rise_shaping_en  <= (next_state == tpg_pkg::TPG_SH_RISE) && !sc_bypass;
         tx_power_level <= next_power;
         tau_fall       <= next_fall;
         tau_rise       <= next_rise;
      end
   end

   assign shape_state = state;

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);

   gear_advance_a: assert property (ce && en && go_up && gear <= gear_last |=> gear == $past(gear) + 3'h1)
      else $error("gear did not advance on high gain");
   gear_zero_a: assert property (ce && !en |=> gear == 3'h0 ##1 (!$past(ce) || !$past(en) || gear <= 3'h1))
      else $error("gear not held at zero while disabled");
   up_cause_a: assert property ($past(ce) && gear > $past(gear) |-> $past(agc_valid) && $past(agc_value) > $past(thr_cur))
      else $error("gear rose without gain above threshold");
   table_index_a: assert property (mp.a_addr == gear && (gear <= gear_last || $past(gear_count) != gear_count || !en))
      else $error("gear table index mismatch");
   no_jump_a: assert property ($past(state) == tpg_pkg::TPG_SH_CW |-> state != tpg_pkg::TPG_SH_MOD)
      else $error("carrier jumped straight to modulated");
   mod_after_fall_a: assert property ($rose(state == tpg_pkg::TPG_SH_MOD) |-> $past(state) == tpg_pkg::TPG_SH_FALL && $past(cnt) == $past(us_len))
      else $error("modulated state not entered after undershoot");
   carrier_off_a: assert property (state == tpg_pkg::TPG_SH_MOD && full_am |-> carrier_level == tpg_pkg::CARRIER_OFF)
      else $error("carrier not off at full depth");
   rise_shape_a: assert property (ce && state == tpg_pkg::TPG_SH_MOD && !mod_req && !sc_bypass |=> switched_cap_rise_shaping_en && state == tpg_pkg::TPG_SH_RISE)
      else $error("rising edge shaping missing");
   // The settings memory is not reset, so the follow check compares identically until entry 0 is written.
   tau_follow_a: assert property (ce && $past(ce) |=> tau_fall === $past(mp.a_data[11:8]) && tau_rise === $past(mp.a_data[15:12]))
      else $error("edge time constants do not follow gear");
   gear_down_a: assert property (ce && en && go_down && !go_up && gear <= gear_last |=> gear == $past(gear) - 3'h1)
      else $error("gear did not step back on low gain");
   gear_cap_a: assert property (ce && en && gear == gear_last && agc_valid |=> gear <= $past(gear))
      else $error("gear advanced past last gear");

   up_cov: cover property (ce && en && go_up);
   down_cov: cover property (ce && en && go_down && !go_up);
   pulse_cov: cover property (state == tpg_pkg::TPG_SH_RISE ##1 state == tpg_pkg::TPG_SH_CW);
   last_cov: cover property (en && gear == gear_last && gear != 3'h0);
endmodule

/* File: verification/tpg_far_end.sv */
// Far-end model: the receiver gain measurement that feeds the power gear controller.
// Assumes the controller's clk_sys and rst_b; the bench sets the load that the model reports.
`timescale 1ns/1ps
module tpg_far_end (
   input  wire logic       clk_sys,
   input  wire logic       rst_b,
   input  wire logic       sample,
   input  wire logic [9:0] load,
   output logic      [9:0] agc_value,
   output logic            agc_valid
);
   logic [9:0] next_agc_value;
   logic       next_agc_valid;

   // Between samples the value lines alternate between the inverted last sample and the last sample itself.
   always_comb begin
      next_agc_valid = sample;
      next_agc_value = sample ? load : ~agc_value;
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         agc_value <= 10'h155;
         agc_valid <= 1'b0;
      end else begin
         agc_value <= next_agc_value;
         agc_valid <= next_agc_valid;
      end
   end
endmodule

/* File: verification/tb.sv */
// Self-checking bench for the transmit power gear and pulse shaping controller.
// Assumes tpg_pkg, tpg_mem_if, tpg_gear_mem, tpg_ctrl and tpg_far_end are compiled first.
`timescale 1ns/1ps
module tb;
   localparam int LIMIT = 6000;
   logic        clk_sys, rst_b, ce, reg_wr, reg_rd, mod_req, sample, agc_valid, undershoot_en, switched_cap_rise_shaping_en;
   logic [7:0]  reg_addr, tx_power_level;
   logic [31:0] reg_wdata, reg_rdata, rd_word;
   logic [9:0]  agc_value, load;
   logic [2:0]  gear;
   logic [3:0]  tau_fall, tau_rise;
   logic [6:0]  carrier_level;
   logic [1:0]  shape_state;
   int          failures, compares, cycles, g, sh, st, cnt, us_len, rise_len, full_am, bypass, resid, last_v;
   int          thr[8];
   int          cfg[8];
   int          exp_q[$];
   int unsigned seed;

   tpg_ctrl DUT (.clk_sys(clk_sys), .rst_b(rst_b), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .agc_value(agc_value), .agc_valid(agc_valid),
      .mod_req(mod_req), .gear(gear), .tx_power_level(tx_power_level), .tau_fall(tau_fall),
      .tau_rise(tau_rise), .carrier_level(carrier_level), .undershoot_en(undershoot_en),
      .switched_cap_rise_shaping_en(switched_cap_rise_shaping_en), .shape_state(shape_state));

   tpg_far_end far (.clk_sys(clk_sys), .rst_b(rst_b), .sample(sample), .load(load), .agc_value(agc_value),
      .agc_valid(agc_valid));

   // -------------------------------------------------------------------------
   // Helpers
   // -------------------------------------------------------------------------
   function automatic int unsigned xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   function automatic int lowthr(input int n);
      return thr[n-1] - (thr[n-1] >> sh);
   endfunction

   task automatic chk(input logic [31:0] seen, input logic [31:0] want, input string what);
      compares++;
      if (seen !== want) begin
         failures++;
         $display("BAD t=%0t %s seen %h want %h", $time, what, seen, want);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk_sys);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask

   // Sends one gain sample, steps the gear model and checks the gear and its table entry.
   task automatic send(input int v);
      int up;
      up = (v > thr[g]) && (g < 4);
      @(posedge clk_sys);
      sample <= 1'b1;
      load <= 10'(v);
      @(posedge clk_sys);
      sample <= 1'b0;
      last_v = v;
      if (up) g++;
      else if (g > 0 && sh != 0 && v < lowthr(g)) g--;
      repeat (4) @(posedge clk_sys);
      #1;
      chk(32'(gear), 32'(g), "gear");
      chk(32'(tx_power_level), 32'(cfg[g] & 255), "power");
      chk(32'(tau_fall), 32'((cfg[g] >> 8) & 15), "tau fall");
      chk(32'(tau_rise), 32'((cfg[g] >> 12) & 15), "tau rise");
   endtask

   task automatic tally_and_finish();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end

   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == LIMIT) begin
         failures++;
         tally_and_finish();
      end
   end

   // -------------------------------------------------------------------------
   // Main sequence
   // -------------------------------------------------------------------------
   initial begin
      seed = 91;
      rst_b = 1'b0;
      ce = 1'b1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 32'h0000_0000;
      mod_req = 1'b0;
      sample = 1'b0;
      load = 10'h000;
      repeat (2) @(posedge clk_sys);
      rst_b <= 1'b1;
      #1;
      chk(32'(gear), 32'h0000_0000, "reset gear");
      chk(32'(carrier_level), 32'h0000_007F, "reset carrier");
      chk(32'(shape_state), 32'h0000_0000, "reset shape");
      wr(8'h14, 32'hFFFF_FFFF);
      exp_q = '{32'h00, 0, 32'h04, 1, 32'h08, 0, 32'h10, 0, 32'h14, 0, 32'h60, 0};
      for (int i = 0; i < 8; i++) begin
         exp_q.push_back(32'(tpg_pkg::OFS_THR_BASE) + 4 * i);
         exp_q.push_back(32'h0000_03FF);
      end
      while (exp_q.size() > 1) begin
         rd(8'(exp_q.pop_front()), rd_word);
         chk(rd_word, 32'(exp_q.pop_front()), "register reset");
      end
      $display("test reset done");
      sh = 2;
      wr(tpg_pkg::OFS_GEAR_COUNT, 32'h0000_0005);
      wr(tpg_pkg::OFS_SHIFT, 32'(sh));
      for (int i = 0; i < 8; i++) begin
         cfg[i] = int'(xs());
         thr[i] = (i < 5) ? 200 + 100 * i + int'(xs() % 32) : 1023;
         wr(tpg_pkg::OFS_SET_BASE + 8'(4 * i), 32'(cfg[i]));
         wr(tpg_pkg::OFS_THR_BASE + 8'(4 * i), 32'(thr[i]));
      end
      for (int i = 0; i < 8; i++) begin
         rd(tpg_pkg::OFS_SET_BASE + 8'(4 * i), rd_word);
         chk(rd_word, 32'(cfg[i]), "settings entry");
         rd(tpg_pkg::OFS_THR_BASE + 8'(4 * i), rd_word);
         chk(rd_word, 32'(thr[i]), "threshold entry");
      end
      $display("test config done");
      g = 0;
      wr(tpg_pkg::OFS_CTRL, 32'h0000_0001);
      for (int k = 0; k < 40; k++) begin
         if (k == 0) send(thr[0]);
         else if (k < 7) send(thr[g] + 1);
         else if (k < 13) send(g > 0 ? lowthr(g) - 1 : 0);
         else send(int'(xs() % 1024));
      end
      sh = 0;
      wr(tpg_pkg::OFS_SHIFT, 32'h0000_0000);
      send(thr[g] + 1);
      send(0);
      rd(tpg_pkg::OFS_STATUS, rd_word);
      chk(rd_word & 32'h03FF_0037, 32'(g | (last_v << 16)), "status");
      wr(tpg_pkg::OFS_GEAR_COUNT, 32'h0000_0000);
      g = 0;
      repeat (4) @(posedge clk_sys);
      #1;
      chk(32'(gear), 32'h0000_0000, "count zero gear");
      chk(32'(tx_power_level), 32'(cfg[0] & 255), "count zero power");
      wr(tpg_pkg::OFS_CTRL, 32'h0000_0000);
      g = 0;
      repeat (2) @(posedge clk_sys);
      #1;
      chk(32'(gear), 32'h0000_0000, "disabled gear");
      @(posedge clk_sys);
      ce <= 1'b0;
      wr(tpg_pkg::OFS_GEAR_COUNT, 32'h0000_0003);
      ce <= 1'b1;
      rd(tpg_pkg::OFS_GEAR_COUNT, rd_word);
      chk(rd_word, 32'h0000_0000, "frozen count");
      $display("test gears done");
      st = 0;
      for (int m = 0; m < 3; m++) begin
         full_am = (m != 1);
         bypass = (m == 2);
         us_len = int'(xs() % 4);
         rise_len = int'(xs() % 4);
         resid = (cfg[0] >> 16) & 127;
         wr(tpg_pkg::OFS_CTRL, 32'(1 | (full_am << 1) | (bypass << 2) | (us_len << 4) | (rise_len << 8)));
         for (int c = 0; c < 60; c++) begin
            @(posedge clk_sys);
            case (st)
               0: if (mod_req) begin
                  st = 1;
                  cnt = us_len;
               end
               1: if (cnt == 0) st = 2; else cnt--;
               2: if (!mod_req) begin
                  st = 3;
                  cnt = rise_len;
               end
               default: if (cnt == 0) st = 0; else cnt--;
            endcase
            mod_req <= (c < 40) && (xs() % 3 != 0);
            #1;
            chk(32'(shape_state), 32'(st), "shape state");
            chk(32'(undershoot_en), 32'(st == 1), "undershoot");
            chk(32'(switched_cap_rise_shaping_en), 32'(st == 3 && !bypass), "rise shaping");
            chk(32'(carrier_level), 32'(st == 0 ? 127 : (st == 2 && full_am) ? 0 : resid), "carrier");
         end
      end
      $display("test shaping done");
      tally_and_finish();
   end
endmodule
